// >>> wide_reg_dev.sv
// Wide-register end: five 16-bit timer words reached as byte pairs.
// Assumes the host keeps upper-then-lower for writes, lower-then-upper for
// reads, and never asserts wr and rd together.
// Also assumes capture strobes come from the same clock as the bus.
//
// How it works
// - Each word moves as two byte accesses, or as a lone lower write that reuses the held upper byte
// - One upper-byte holding register per timer
// - Holding register shared by all words of its timer
// - Only the lower byte address moves words
// - Lower write loads holding plus byte together
// - Lower read copies upper byte to holding
// - Host writes upper byte before lower byte
// - Host reads lower byte before upper byte
// - Host keeps each byte pair uninterrupted
// - One upper write may serve several words
`timescale 1ns/1ps

`include "wide_access_regs.svh"

module wide_reg_dev
    import wide_access_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    wide_bus_if.dev bus,
    // Timer side: capture strobes and values, one per register
    input wire logic [`NUM_WIDE_REGS-1:0] capture_load,
    input wire logic [`NUM_WIDE_REGS-1:0][15:0] capture_value,
    // Timer side: current words and a pulse when the CPU loads one
    output logic [`NUM_WIDE_REGS-1:0][15:0] reg_words,
    output logic [`NUM_WIDE_REGS-1:0] word_loaded,
    output logic [`NUM_TIMERS-1:0][7:0] holding_bytes
);

    // Which timer owns each word, and which words the timer may fill
    localparam logic [`NUM_WIDE_REGS-1:0] timer3_map = `TIMER3_MAP;
    localparam logic [`NUM_WIDE_REGS-1:0] capture_map = `CAPTURE_MAP;
    localparam logic [2:0] num_regs = 3'(`NUM_WIDE_REGS);

    // Wide words and their load pulses
    word_t word_q [`NUM_WIDE_REGS];
    logic [`NUM_WIDE_REGS-1:0] loaded_q;

    // One holding byte per timer
    byte_t hold_q [`NUM_TIMERS];

    // Read answer
    byte_t rdata_q;
    logic rvalid_q;

    // Address decode
    wire reg_index_t sel_index;
    wire logic sel_upper;
    wire logic sel_valid;
    wire logic sel_timer;
    wire logic wr_hit;
    wire logic rd_hit;
    wire logic wr_lower;
    wire logic wr_upper;
    wire logic rd_lower;
    wire logic rd_upper;

    assign sel_index = bus.addr[`ADDR_INDEX_MSB:`ADDR_INDEX_LSB];
    assign sel_upper = bus.addr[`ADDR_UPPER_BIT];
    // Indices past the last word are unmapped
    assign sel_valid = sel_index < num_regs;
    // Unmapped indices land on timer2 but never reach its holding byte
    assign sel_timer = sel_valid ? timer3_map[sel_index] : 1'b0;
    // Every access is qualified once by the index range
    assign wr_hit = bus.wr && sel_valid;
    assign rd_hit = bus.rd && sel_valid;
    assign wr_lower = wr_hit && !sel_upper;
    assign wr_upper = wr_hit && sel_upper;
    assign rd_lower = rd_hit && !sel_upper;
    assign rd_upper = rd_hit && sel_upper;

    // Read data selection
    wire word_t sel_word;
    wire byte_t sel_lower_byte;
    wire byte_t sel_upper_byte;
    wire byte_t sel_hold;
    wire byte_t read_byte;

    // Out-of-range index would read past the array, so force zero
    assign sel_word = sel_valid ? word_q[sel_index] : `WORD_RESET;
    assign sel_lower_byte = sel_word[7:0];
    assign sel_upper_byte = sel_word[15:8];
    assign sel_hold = hold_q[sel_timer];
    // The upper address answers from holding, never from the live word
    assign read_byte = rd_lower ? sel_lower_byte :
                       rd_upper ? sel_hold :
                       `UNMAPPED_READ;

    // Holding registers, one per timer
    // Shared by every word of the timer: a second master that slips in
    // between the halves of a pair corrupts it, so software masks it out
    genvar t;
    generate
        for (t = 0; t < `NUM_TIMERS; t++) begin : g_hold
            wire logic mine;
            wire logic load_upper;
            wire logic snap_upper;
            wire byte_t hold_d;

            // Upper writes load it, lower reads refresh it
            assign mine = sel_timer == 1'(t);
            assign load_upper = wr_upper && mine;
            assign snap_upper = rd_lower && mine;
            // One bus access per cycle, so load and snapshot never meet
            assign hold_d = load_upper ? bus.wdata :
                            snap_upper ? sel_upper_byte :
                            hold_q[t];

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    hold_q[t] <= `BYTE_RESET;
                end else begin
                    hold_q[t] <= hold_d;
                end
            end

            // Timer side may watch a pending upper byte
            assign holding_bytes[t] = hold_q[t];
        end
    endgenerate

    // Per-register strobes
    wire logic [`NUM_WIDE_REGS-1:0] lower_hit;
    wire logic [`NUM_WIDE_REGS-1:0] capture_hit;
    wire logic [`NUM_WIDE_REGS-1:0] loaded_d;

    // Compare words ignore capture strobes
    assign capture_hit = capture_load & capture_map;
    // A capture beats a CPU write in the same cycle; that write is lost
    assign loaded_d = lower_hit & ~capture_hit;

    // Wide words
    genvar r;
    generate
        for (r = 0; r < `NUM_WIDE_REGS; r++) begin : g_word
            wire logic own_timer;
            wire byte_t own_hold;
            wire word_t cpu_word;
            wire word_t word_d;

            // Only a mapped lower-byte write moves a word
            assign lower_hit[r] = wr_lower && sel_index == 3'(r);
            assign own_timer = timer3_map[r];
            assign own_hold = hold_q[own_timer];
            // Upper byte from the word's own timer holding register
            assign cpu_word = {own_hold, bus.wdata};
            // Capture first, then the CPU, else keep
            assign word_d = capture_hit[r] ? capture_value[r] :
                            lower_hit[r] ? cpu_word :
                            word_q[r];

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    word_q[r] <= `WORD_RESET;
                end else begin
                    word_q[r] <= word_d;
                end
            end

            assign reg_words[r] = word_q[r];
        end
    endgenerate

    // Tells the timer side that a new CPU value has arrived
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loaded_q <= '0;
        end else begin
            loaded_q <= loaded_d;
        end
    end

    assign word_loaded = loaded_q;

    // Registered read answer, one cycle after the read edge
    // Zero between answers so a stale byte never looks like fresh data
    wire byte_t rdata_d;
    wire logic rvalid_d;

    assign rdata_d = bus.rd ? read_byte : `BYTE_RESET;
    // Every read is answered, mapped or not
    assign rvalid_d = bus.rd;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= `BYTE_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rvalid_d;
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.rvalid = rvalid_q;

endmodule

// >>> wide_access_regs.svh
// Byte addresses, field positions and reset values of the wide-register path.
// Assumes an 8-bit byte-wide CPU bus with a 4-bit byte address.
`ifndef WIDE_ACCESS_REGS_SVH
`define WIDE_ACCESS_REGS_SVH

`define BYTE_ADDR_W 4
`define NUM_WIDE_REGS 5
`define NUM_TIMERS 2

// Register index sits above the byte select bit
`define ADDR_UPPER_BIT 0
`define ADDR_INDEX_LSB 1
`define ADDR_INDEX_MSB 3

`define IDX_TIMER2_CAPTURE 3'h0
`define IDX_TIMER2_COMPARE 3'h1
`define IDX_TIMER3_CAPTURE 3'h2
`define IDX_TIMER3_COMPARE_A 3'h3
`define IDX_TIMER3_COMPARE_B 3'h4

// One bit per register: set where the register belongs to timer3
`define TIMER3_MAP 5'h1c
// One bit per register: set where the timer side may capture into it
`define CAPTURE_MAP 5'h05

`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define UNMAPPED_READ 8'h00

`endif

// >>> wide_access_pkg.sv
// Types shared by both ends of the wide-register path.
// Assumes wide_access_regs.svh supplies the numbers.
`include "wide_access_regs.svh"

package wide_access_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef logic [`BYTE_ADDR_W-1:0] byte_addr_t;
    typedef logic [2:0] reg_index_t;
    typedef enum logic [2:0] {
        st_idle,
        st_wr_upper,
        st_wr_lower,
        st_rd_lower,
        st_rd_upper,
        st_rd_end
    } host_state_e;
endpackage

// >>> wide_bus_if.sv
// Byte-wide CPU bus between the host end and the wide-register end.
// Assumes both ends share one clock; all signals are sampled at its edge.
`timescale 1ns/1ps

interface wide_bus_if;
    import wide_access_pkg::*;
    byte_addr_t addr;
    byte_t wdata;
    logic wr;
    logic rd;
    byte_t rdata;
    logic rvalid;

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input rvalid
    );

    modport dev (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output rvalid
    );
endinterface

// >>> wide_reg_host.sv
// Host end: turns 16-bit user commands into ordered byte accesses.
// Assumes the device answers a read one cycle after the read edge.
`timescale 1ns/1ps

`include "wide_access_regs.svh"

module wide_reg_host
    import wide_access_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    wide_bus_if.host bus,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_keep_upper,
    input wire reg_index_t cmd_index,
    input wire word_t cmd_wdata,
    output logic cmd_ready,
    output logic cmd_done,
    output logic [15:0] cmd_rdata
);

    host_state_e state_q;
    byte_addr_t addr_q;
    byte_t wdata_q;
    byte_t lower_q;
    logic wr_q;
    logic rd_q;
    logic ready_q;
    logic done_q;
    word_t rdata_q;
    word_t pend_q;

    wire logic accept;
    wire byte_addr_t lower_addr;
    wire byte_addr_t upper_addr;

    assign accept = cmd_valid && ready_q && state_q == st_idle;
    assign lower_addr = {cmd_index, 1'b0};
    assign upper_addr = {cmd_index, 1'b1};

    // Commands are taken only when idle, so a byte pair is never split
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= st_idle;
            addr_q <= '0;
            wdata_q <= `BYTE_RESET;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            rdata_q <= `WORD_RESET;
            pend_q <= `WORD_RESET;
            lower_q <= `BYTE_RESET;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                st_idle: begin
                    if (accept) begin
                        ready_q <= 1'b0;
                        pend_q <= cmd_wdata;
                        if (cmd_write && cmd_keep_upper) begin
                            addr_q <= lower_addr;
                            wdata_q <= cmd_wdata[7:0];
                            wr_q <= 1'b1;
                            state_q <= st_wr_lower;
                        end else if (cmd_write) begin
                            addr_q <= upper_addr;
                            wdata_q <= cmd_wdata[15:8];
                            wr_q <= 1'b1;
                            state_q <= st_wr_upper;
                        end else begin
                            addr_q <= lower_addr;
                            rd_q <= 1'b1;
                            state_q <= st_rd_lower;
                        end
                    end
                end
                st_wr_upper: begin
                    addr_q <= {addr_q[3:1], 1'b0};
                    wdata_q <= pend_q[7:0];
                    state_q <= st_wr_lower;
                end
                st_wr_lower: begin
                    wr_q <= 1'b0;
                    done_q <= 1'b1;
                    ready_q <= 1'b1;
                    state_q <= st_idle;
                end
                st_rd_lower: begin
                    addr_q <= {addr_q[3:1], 1'b1};
                    state_q <= st_rd_upper;
                end
                st_rd_upper: begin
                    rd_q <= 1'b0;
                    lower_q <= bus.rdata;
                    state_q <= st_rd_end;
                end
                st_rd_end: begin
                    rdata_q <= {bus.rdata, lower_q};
                    done_q <= 1'b1;
                    ready_q <= 1'b1;
                    state_q <= st_idle;
                end
                default: begin
                    state_q <= st_idle;
                    wr_q <= 1'b0;
                    rd_q <= 1'b0;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign cmd_ready = ready_q;
    assign cmd_done = done_q;
    assign cmd_rdata = rdata_q;

endmodule

// >>> wide_access_properties.sv
// Bus-level checks for the byte-wide wide-register link.
// Assumes it sits beside the interface joining host and device ends.
`timescale 1ns/1ps

module wide_access_properties
    import wide_access_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire byte_addr_t addr,
    input wire byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire byte_t rdata,
    input wire logic rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_read_answer;
        rd |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read got no answer");

    property p_no_stray;
        !rd |=> !rvalid;
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("answer without a read");

    property p_idle_rdata;
        !rvalid |-> rdata == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read byte not zero when idle");

    property p_write_order;
        wr && addr[0] |=> wr && !addr[0] && addr[3:1] == $past(addr[3:1]);
    endproperty
    a_write_order: assert property (p_write_order)
        else $error("upper write not followed by its lower write");

    property p_write_end;
        wr && !addr[0] |=> !wr;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("write strobe held past lower byte");

    property p_read_order;
        rd && !addr[0] |=> rd && addr[0] && addr[3:1] == $past(addr[3:1]);
    endproperty
    a_read_order: assert property (p_read_order)
        else $error("lower read not followed by its upper read");

    property p_upper_after_lower;
        rd && addr[0] |-> $past(rd) && !$past(addr[0]);
    endproperty
    a_upper_after_lower: assert property (p_upper_after_lower)
        else $error("upper read without lower read before");

    property p_one_access;
        !(wr && rd);
    endproperty
    a_one_access: assert property (p_one_access)
        else $error("read and write together");

    property p_unmapped_zero;
        rd && addr[3:1] > 3'h4 |=> rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    c_write_pair: cover property (wr && addr[0] ##1 wr && !addr[0]);
    c_read_pair: cover property (rd && !addr[0] ##1 rd ##1 rvalid);
    c_lone_lower: cover property (!wr ##1 wr && !addr[0] && wdata != 8'h00);
endmodule

// >>> timer_wide_register_byte_access_tb.sv
// Testbench: host and device ends joined by the byte bus.
// Assumes the host issues ordered byte pairs for each 16-bit command, or the lower byte alone for a keep-upper write.
`timescale 1ns/1ps

module timer_wide_register_byte_access_tb;
    import wide_access_pkg::*;
    typedef struct packed {reg_index_t idx; word_t wdata; logic tmr;} row_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_keep_upper = 1'b0;
    reg_index_t cmd_index = 3'h0;
    word_t cmd_wdata = 16'h0000;
    logic [4:0] capture_load = 5'h00;
    logic [4:0][15:0] capture_value = '0;
    logic [4:0][15:0] reg_words;
    logic [4:0] word_loaded;
    logic [1:0][7:0] holding_bytes;
    logic cmd_ready;
    logic cmd_done;
    logic [15:0] cmd_rdata;
    int n_checks = 0;
    int miscompares = 0;
    row_s rows [5] = '{'{3'h0, 16'h01ff, 1'b0}, '{3'h1, 16'h8001, 1'b0},
        '{3'h2, 16'hffff, 1'b1}, '{3'h3, 16'h7e00, 1'b1},
        '{3'h4, 16'h00a5, 1'b1}};

    always #50 clk = ~clk;

    wide_bus_if bus ();
    wide_reg_dev i_wide_reg_dev (.clk(clk), .reset(reset), .bus(bus.dev),
        .capture_load(capture_load), .capture_value(capture_value),
        .reg_words(reg_words), .word_loaded(word_loaded),
        .holding_bytes(holding_bytes));
    wide_reg_host i_wide_reg_host (.clk(clk), .reset(reset), .bus(bus.host),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_keep_upper(cmd_keep_upper), .cmd_index(cmd_index),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .cmd_rdata(cmd_rdata));
    wide_access_properties i_wide_access_properties (.clk(clk),
        .reset(reset), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
        .rd(bus.rd), .rdata(bus.rdata), .rvalid(bus.rvalid));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input word_t exp, input word_t got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered 10 ns after an edge with the host ready
    task automatic cmd(input logic w, k, input reg_index_t i, input word_t d);
        int n;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_keep_upper = k;
        cmd_index = i;
        cmd_wdata = d;
        @(posedge clk);
        #10 cmd_valid = 1'b0;
        chk("busy", 16'h0000, 16'(cmd_ready));
        n = 0;
        while (cmd_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #10 n++;
        end
        if (n == 20) begin
            miscompares++;
            close_out();
        end
        chk("ready", 16'h0001, 16'(cmd_ready));
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #10 reset = 1'b0;
        chk("reset hold", 16'h0000, {8'h00, holding_bytes[1]});
        for (int r = 0; r < 5; r++) begin
            cmd(1'b1, 1'b0, rows[r].idx, rows[r].wdata);
            chk("word", rows[r].wdata, reg_words[rows[r].idx]);
            chk("loaded", 16'(5'h01 << rows[r].idx), 16'(word_loaded));
            chk("hold", {8'h00, rows[r].wdata[15:8]},
                {8'h00, holding_bytes[rows[r].tmr]});
            cmd(1'b0, 1'b0, rows[r].idx, 16'h0000);
            chk("read", rows[r].wdata, cmd_rdata);
        end
        // Second timer3 word reuses the upper byte left by the first
        cmd(1'b1, 1'b0, 3'h3, 16'hab12);
        cmd(1'b1, 1'b1, 3'h4, 16'hcd34);
        chk("keep upper", 16'hab34, reg_words[4]);
        chk("timer2 hold", 16'h0080, {8'h00, holding_bytes[0]});
        capture_value[1] = 16'h3c3c;
        capture_value[2] = 16'h5a6b;
        capture_load = 5'h06;
        @(posedge clk);
        #10 capture_load = 5'h00;
        chk("no capture", 16'h8001, reg_words[1]);
        cmd(1'b0, 1'b0, 3'h2, 16'h0000);
        chk("capture read", 16'h5a6b, cmd_rdata);
        chk("hold copy", 16'h005a, {8'h00, holding_bytes[1]});
        cmd(1'b1, 1'b1, 3'h0, 16'h0077);
        chk("lower only", 16'h8077, reg_words[0]);
        cmd(1'b1, 1'b0, 3'h5, 16'h1234);
        cmd(1'b0, 1'b0, 3'h5, 16'h0000);
        chk("unmapped", 16'h0000, cmd_rdata);
        chk("unmapped hold", 16'h005a, {8'h00, holding_bytes[1]});
        chk("unmapped hold0", 16'h0080, 16'(holding_bytes[0]));
        reset = 1'b1;
        @(posedge clk);
        #10 chk("reset word", 16'h0000, reg_words[1]);
        reset = 1'b0;
        @(posedge clk);
        #10 cmd(1'b0, 1'b0, 3'h1, 16'h0000);
        chk("read after reset", 16'h0000, cmd_rdata);
        close_out();
    end
endmodule
